// >>> tb/test_embedded_memory_block.sv
// testbench for the embedded memory / product-term block
`default_nettype none
module test_embedded_memory_block
  import emb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic out_clk_i = 1'b0;
  logic reset_n_i;
  logic [1:0] ctrl_src_i;
  logic clk_en_dedicated_i, clk_en_global_i, clk_en_local_i;
  logic clr_n_dedicated_i, clr_n_global_i, clr_n_local_i;
  logic pterm_mode_i;
  logic [1:0] mem_func_i;
  logic [2:0] shape_i;
  logic [5:0] path_reg_i;
  logic [MACRO_N-1:0] mc_reg_en_i;
  logic [MACRO_N*2*LIT_W-1:0] term_mask_i, term_inv_i;
  logic write_request_i, read_request_i;
  logic [ADDR_W-1:0] waddr_i, raddr_i, cam_addr_o;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic cam_hit_o, fifo_empty_o, fifo_full_o;
  logic [PT_IN_W-1:0] pt_in_i;
  logic [MACRO_N-1:0] mc_out_o;
  logic [LOCAL_OUT_N-1:0] local_out_o;
  int err_total = 0;
  int n_tests = 0;
  always #5 clk_i = ~clk_i;
  // read side clock of unrelated rate
  always #7 out_clk_i = ~out_clk_i;
  user_logic_cells pl (.clk_i, .write_request_o(write_request_i), .waddr_o(waddr_i),
    .wdata_o(wdata_i), .read_request_o(read_request_i), .raddr_o(raddr_i));
  embedded_memory_block i_dut (.clk_i, .reset_n_i, .out_clk_i, .ctrl_src_i,
    .clk_en_dedicated_i, .clk_en_global_i, .clk_en_local_i, .clr_n_dedicated_i,
    .clr_n_global_i, .clr_n_local_i, .pterm_mode_i, .mem_func_i, .shape_i, .path_reg_i,
    .mc_reg_en_i, .term_mask_i, .term_inv_i, .write_request_i, .waddr_i, .wdata_i,
    .read_request_i, .raddr_i, .rdata_o, .cam_hit_o, .cam_addr_o, .fifo_empty_o,
    .fifo_full_o, .pt_in_i, .mc_out_o, .local_out_o);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    close_out();
  end
  initial begin
    reset_n_i = 1'b0;
    ctrl_src_i = SRC_LOCAL;
    {clk_en_dedicated_i, clk_en_global_i, clk_en_local_i} = 3'h7;
    {clr_n_local_i, clr_n_global_i, clr_n_dedicated_i} = 3'h7;
    pterm_mode_i = 1'b0;
    mem_func_i = FUNC_DUAL_PORT;
    shape_i = SHAPE_128X16;
    path_reg_i = 6'h00;
    mc_reg_en_i = 16'h0004;
    pt_in_i = '0;
    term_mask_i = '0;
    term_inv_i = '0;
    // cell 0: in0 or in1, cell 1: fed back cell 0, cell 2: in2 registered, cell 15: not in31
    term_mask_i[0] = 1'b1;
    term_mask_i[LIT_W+1] = 1'b1;
    term_mask_i[2*LIT_W+32] = 1'b1;
    term_mask_i[3*LIT_W+32] = 1'b1;
    term_mask_i[4*LIT_W+2] = 1'b1;
    term_mask_i[5*LIT_W+2] = 1'b1;
    term_mask_i[30*LIT_W+31] = 1'b1;
    term_mask_i[31*LIT_W+31] = 1'b1;
    term_inv_i[30*LIT_W+31] = 1'b1;
    term_inv_i[31*LIT_W+31] = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    for (int s = 0; s < 5; s++) begin
      shape_i = 3'(s);
      pl.put_write(11'((128 << s) - 1), 16'h5a3c);
      pl.put_read(11'((128 << s) - 1));
      #1 check(rdata_o, 32'(16'h5a3c & ((17'h1 << (16 >> s)) - 1)));
    end
    $display("test shapes done");
    shape_i = SHAPE_128X16;
    pl.put_write(11'h003, 16'h1111);
    @(posedge clk_i);
    #1 pl.put_write(11'h004, 16'h0bad);
    @(posedge clk_i);
    #1 pl.put_read(11'h003);
    fork
      pl.put_write(11'h003, 16'hc001);
      #1 check(rdata_o, 16'h1111);
    join
    #1 check(rdata_o, 16'hc001);
    $display("test same period done");
    path_reg_i = 6'h02;
    @(posedge out_clk_i);
    #1 pl.put_read(11'h004);
    #1 check(rdata_o, 16'hc001);
    @(posedge out_clk_i);
    #1 check(rdata_o, 16'h0bad);
    for (int s = 0; s < 3; s++) begin
      ctrl_src_i = 2'(s);
      {clr_n_local_i, clr_n_global_i, clr_n_dedicated_i} = 3'b001 << s;
      repeat (3) @(posedge out_clk_i);
      #1 check(rdata_o, 16'h0bad);
      {clr_n_local_i, clr_n_global_i, clr_n_dedicated_i} = 3'h0;
      repeat (3) @(posedge out_clk_i);
      #1 check(rdata_o, 16'h0000);
      {clr_n_local_i, clr_n_global_i, clr_n_dedicated_i} = 3'h7;
      repeat (3) @(posedge out_clk_i);
      #1 check(rdata_o, 16'h0bad);
    end
    $display("test output register and clear done");
    path_reg_i = 6'h04;
    pl.put_read(11'h003);
    #1 check(rdata_o, 16'h0bad);
    @(posedge out_clk_i);
    #1 check(rdata_o, 16'hc001);
    path_reg_i = 6'h00;
    @(posedge clk_i);
    #1 mem_func_i = FUNC_ROM;
    pl.put_write(11'h004, 16'hffff);
    pl.put_read(11'h004);
    #1 check(rdata_o, 16'h0bad);
    pl.stop_read();
    mem_func_i = FUNC_FIFO;
    #1 check({fifo_empty_o, fifo_full_o}, 2'b10);
    pl.put_write(11'h000, 16'h0042);
    #1 check({fifo_empty_o, fifo_full_o}, 2'b00);
    mem_func_i = FUNC_CAM;
    pl.put_write(11'h000, 16'h7e57);
    pl.put_key(16'h7e57);
    #1 check({cam_hit_o, cam_addr_o}, 12'h800);
    $display("test functions done");
    mem_func_i = FUNC_DUAL_PORT;
    pterm_mode_i = 1'b1;
    for (int v = 0; v < 4; v++) begin
      pt_in_i = {v[0], 28'h0, v[1], v[1], v[0]};
      #1 check(mc_out_o[0], v[0] | v[1]);
      check(mc_out_o[1], v[0] | v[1]);
      check(mc_out_o[15], !v[0]);
      check({local_out_o[9], local_out_o[0]}, {2{v[0] | v[1]}});
      @(posedge clk_i);
      #1 check(mc_out_o[2], v[1]);
    end
    pl.put_write(11'h004, 16'h1234);
    pterm_mode_i = 1'b0;
    pl.put_read(11'h004);
    #1 check(rdata_o, 16'h0bad);
    check(mc_out_o, 16'h0000);
    check(local_out_o, 10'h3ad);
    // a write offered while the selected clock enable is low must not land
    clk_en_local_i = 1'b0;
    pl.put_write(11'h004, 16'h5555);
    #1 check(rdata_o, 16'h0bad);
    clk_en_local_i = 1'b1;
    $display("test product terms done");
    close_out();
  end
endmodule // test_embedded_memory_block
`default_nettype wire

// >>> tb/user_logic_cells.sv
// model of the adjacent logic cells that drive the memory request side
`default_nettype none
module user_logic_cells
  import emb_pkg::*;
(
  // clock
  input wire logic clk_i,
  // requests and their address and data
  output logic write_request_o,
  output logic [ADDR_W-1:0] waddr_o,
  output logic [DATA_W-1:0] wdata_o,
  output logic read_request_o,
  output logic [ADDR_W-1:0] raddr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    write_request_o = 1'b0;
    waddr_o = '0;
    wdata_o = '0;
    read_request_o = 1'b0;
    raddr_o = '0;
  end
  // plain level request held over one capture edge, no pulse shaping
  task automatic put_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    waddr_o = a;
    wdata_o = d;
    write_request_o = 1'b1;
    @(posedge clk_i);
    #1;
    write_request_o = 1'b0;
    // released lines do not keep the last value
    waddr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic put_read(input logic [ADDR_W-1:0] a);
    raddr_o = a;
    read_request_o = 1'b1;
  endtask
  task automatic stop_read();
    read_request_o = 1'b0;
  endtask
  task automatic put_key(input logic [DATA_W-1:0] d);
    wdata_o = d;
  endtask
endmodule // user_logic_cells
`default_nettype wire

// >>> verilog/emb_pkg.sv
// constants shared by the embedded memory / product-term block
// Contract
// R1 - five memory shapes, 128x16 down to 2048x1
// R2 - dual-port, ROM, FIFO or CAM function chosen
// R3 - write and read same period, separate clocks
// R4 - inputs registered, optional output register
// R5 - block makes its own write strobe
// R6 - each block selects memory or product-term mode
// R7 - sixteen macrocells, two terms, optional register
// R8 - thirty-two routed inputs feed product terms
// R9 - nine macrocell outputs fed back as literals
// R10 - ten local outputs, nine distinct one duplicate
// R11 - control signals selectable from three sources
// R12 - blocks side by side form wider memories
// R13 - full 2048 depth without external decode
// R14 - input and output sides separately clocked
// R15 - each data, address, request path optionally registered
// R16 - user logic drives requests, clocks, clear
// R17 - output register adds one read cycle
// R18 - clear resets registers, not memory contents
`default_nettype none
package emb_pkg;
  localparam int unsigned MEM_BITS = 2048;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PT_IN_W = 32;
  localparam int unsigned MACRO_N = 16;
  localparam int unsigned FB_N = 9;
  localparam int unsigned LOCAL_OUT_N = 10;
  localparam int unsigned LIT_W = PT_IN_W + FB_N;
  // shape select codes
  localparam logic [2:0] SHAPE_128X16 = 3'h0;
  localparam logic [2:0] SHAPE_256X8 = 3'h1;
  localparam logic [2:0] SHAPE_512X4 = 3'h2;
  localparam logic [2:0] SHAPE_1024X2 = 3'h3;
  localparam logic [2:0] SHAPE_2048X1 = 3'h4;
  // register enable bit positions of the path register select
  localparam int unsigned REG_WDATA = 0;
  localparam int unsigned REG_RDATA = 1;
  localparam int unsigned REG_RADDR = 2;
  localparam int unsigned REG_WADDR = 3;
  localparam int unsigned REG_WREQ = 4;
  localparam int unsigned REG_RREQ = 5;
  // control source select codes
  localparam logic [1:0] SRC_DEDICATED = 2'h0;
  localparam logic [1:0] SRC_GLOBAL = 2'h1;
  localparam logic [1:0] SRC_LOCAL = 2'h2;
  typedef enum logic [1:0] {
    FUNC_DUAL_PORT = 2'b00,
    FUNC_ROM = 2'b01,
    FUNC_FIFO = 2'b10,
    FUNC_CAM = 2'b11
  } mem_func_t;
endpackage
`default_nettype wire

// >>> verilog/embedded_memory_block.sv
// embedded memory block: configurable ram/rom/fifo/cam or product-term macrocells
`default_nettype none
module embedded_memory_block
  import emb_pkg::*;
#(
  parameter int unsigned DEPTH_BITS = MEM_BITS
) (
  // clocks and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic out_clk_i,
  // control sources
  input wire logic [1:0] ctrl_src_i,
  input wire logic clk_en_dedicated_i,
  input wire logic clk_en_global_i,
  input wire logic clk_en_local_i,
  input wire logic clr_n_dedicated_i,
  input wire logic clr_n_global_i,
  input wire logic clr_n_local_i,
  // configuration
  input wire logic pterm_mode_i,
  input wire logic [1:0] mem_func_i,
  input wire logic [2:0] shape_i,
  input wire logic [5:0] path_reg_i,
  input wire logic [MACRO_N-1:0] mc_reg_en_i,
  input wire logic [MACRO_N*2*LIT_W-1:0] term_mask_i,
  input wire logic [MACRO_N*2*LIT_W-1:0] term_inv_i,
  // memory write side
  input wire logic write_request_i,
  input wire logic [ADDR_W-1:0] waddr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  // memory read side
  input wire logic read_request_i,
  input wire logic [ADDR_W-1:0] raddr_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic cam_hit_o,
  output logic [ADDR_W-1:0] cam_addr_o,
  output logic fifo_empty_o,
  output logic fifo_full_o,
  // product-term side
  input wire logic [PT_IN_W-1:0] pt_in_i,
  output logic [MACRO_N-1:0] mc_out_o,
  output logic [LOCAL_OUT_N-1:0] local_out_o
);
  if (DEPTH_BITS != MEM_BITS) begin : g_depth_bad
    $error("block holds exactly 2048 bits");
  end
  logic [DEPTH_BITS-1:0] mem_q;
  logic clk_en_w, clr_n_w;
  mem_func_t func_w;
  assign func_w = mem_func_t'(mem_func_i); // see R2
  // control source selection
  assign clk_en_w = (ctrl_src_i == SRC_GLOBAL) ? clk_en_global_i :
                    (ctrl_src_i == SRC_LOCAL) ? clk_en_local_i : clk_en_dedicated_i; // see R11
  assign clr_n_w = (ctrl_src_i == SRC_GLOBAL) ? clr_n_global_i :
                   (ctrl_src_i == SRC_LOCAL) ? clr_n_local_i : clr_n_dedicated_i; // see R11 R16
  // optional input registers, write side
  logic [ADDR_W-1:0] waddr_q, raddr_q, waddr_w, raddr_w;
  logic [DATA_W-1:0] wdata_q, wdata_w;
  logic wreq_q, rreq_q, wreq_w, rreq_w;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      waddr_q <= '0;
      wdata_q <= '0;
      wreq_q <= 1'b0;
    end else if (!clr_n_w) begin
      waddr_q <= '0;
      wdata_q <= '0;
      wreq_q <= 1'b0; // see R18
    end else if (clk_en_w) begin
      waddr_q <= waddr_i;
      wdata_q <= wdata_i;
      wreq_q <= write_request_i; // see R4
    end
  end
  // read side input registers run on the output clock
  always_ff @(posedge out_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      raddr_q <= '0;
      rreq_q <= 1'b0;
    end else if (!clr_n_w) begin
      raddr_q <= '0;
      rreq_q <= 1'b0; // see R18
    end else if (clk_en_w) begin
      raddr_q <= raddr_i;
      rreq_q <= read_request_i; // see R14
    end
  end
  assign waddr_w = path_reg_i[REG_WADDR] ? waddr_q : waddr_i; // see R15
  assign wdata_w = path_reg_i[REG_WDATA] ? wdata_q : wdata_i; // see R15
  assign wreq_w = path_reg_i[REG_WREQ] ? wreq_q : write_request_i; // see R15
  assign raddr_w = path_reg_i[REG_RADDR] ? raddr_q : raddr_i; // see R15
  assign rreq_w = path_reg_i[REG_RREQ] ? rreq_q : read_request_i; // see R15
  // shape: data width and bit index = addr * width
  logic [4:0] width_w;
  logic [ADDR_W-1:0] amask_w;
  assign width_w = (shape_i == SHAPE_128X16) ? 5'h10 : (shape_i == SHAPE_256X8) ? 5'h08 :
                   (shape_i == SHAPE_512X4) ? 5'h04 : (shape_i == SHAPE_1024X2) ? 5'h02 :
                   5'h01; // see R1
  assign amask_w = (shape_i == SHAPE_128X16) ? 11'h07f : (shape_i == SHAPE_256X8) ? 11'h0ff :
                   (shape_i == SHAPE_512X4) ? 11'h1ff : (shape_i == SHAPE_1024X2) ? 11'h3ff :
                   11'h7ff; // see R1 R13
  // fifo pointers replace the user addresses in fifo function
  logic [ADDR_W:0] fifo_wp_q, fifo_rp_q, fifo_cnt_w;
  logic [ADDR_W:0] depth_w;
  assign depth_w = {1'b0, amask_w} + 12'h001;
  assign fifo_cnt_w = fifo_wp_q - fifo_rp_q;
  assign fifo_empty_o = (fifo_cnt_w == 12'h000);
  assign fifo_full_o = (fifo_cnt_w == depth_w);
  logic is_fifo_w, do_write_w, do_read_w;
  assign is_fifo_w = (func_w == FUNC_FIFO);
  // internal write strobe: registered or direct request as path_reg_i selects, in time with the clock
  assign do_write_w = !pterm_mode_i && wreq_w && clk_en_w && clr_n_w && (func_w != FUNC_ROM)
                      && !(is_fifo_w && fifo_full_o); // see R5 R2
  assign do_read_w = !pterm_mode_i && rreq_w && clk_en_w && clr_n_w
                     && !(is_fifo_w && fifo_empty_o);
  logic [ADDR_W-1:0] wa_w, ra_w;
  assign wa_w = (is_fifo_w ? fifo_wp_q[ADDR_W-1:0] : waddr_w) & amask_w;
  assign ra_w = (is_fifo_w ? fifo_rp_q[ADDR_W-1:0] : raddr_w) & amask_w;
  logic [ADDR_W+3:0] wbase_w, rbase_w;
  assign wbase_w = {4'h0, wa_w} * {10'h000, width_w};
  assign rbase_w = {4'h0, ra_w} * {10'h000, width_w};
  // memory array: never touched by clear or reset
  always_ff @(posedge clk_i) begin
    if (do_write_w) begin
      for (int i = 0; i < DATA_W; i++) begin
        if (i < int'(width_w)) mem_q[wbase_w[ADDR_W-1:0] + ADDR_W'(i)] <= wdata_w[i]; // see R18 R3
      end
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fifo_wp_q <= '0;
    end else if (!clr_n_w) begin
      fifo_wp_q <= '0;
    end else if (is_fifo_w && do_write_w) begin
      fifo_wp_q <= fifo_wp_q + 12'h001;
    end
  end
  always_ff @(posedge out_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fifo_rp_q <= '0;
    end else if (!clr_n_w) begin
      fifo_rp_q <= '0;
    end else if (is_fifo_w && do_read_w) begin
      fifo_rp_q <= fifo_rp_q + 12'h001;
    end
  end
  // combinational read word, upper bits zero for narrow shapes
  logic [DATA_W-1:0] rword_w;
  always_comb begin
    rword_w = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (i < int'(width_w)) rword_w[i] = mem_q[rbase_w[ADDR_W-1:0] + ADDR_W'(i)];
    end
  end
  // cam: search the word presented on write data across all words of the shape
  always_comb begin
    logic match;
    match = 1'b0;
    cam_hit_o = 1'b0;
    cam_addr_o = '0;
    for (int a = MEM_BITS - 1; a >= 0; a--) begin
      if (func_w == FUNC_CAM && ADDR_W'(a) <= amask_w) begin
        match = 1'b1;
        for (int i = 0; i < DATA_W; i++) begin
          if (i < int'(width_w) && (a * int'(width_w) + i) < MEM_BITS)
            match = match && (mem_q[a * int'(width_w) + i] == wdata_w[i]);
        end
        if (match) begin
          cam_hit_o = 1'b1;
          cam_addr_o = ADDR_W'(a);
        end
      end
    end
  end
  // output register on the output clock
  logic [DATA_W-1:0] rdata_q;
  always_ff @(posedge out_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= '0;
    end else if (!clr_n_w) begin
      rdata_q <= '0; // see R18
    end else if (do_read_w || !rreq_w) begin
      rdata_q <= rword_w; // see R17 R4
    end
  end
  // shared address and narrow word in low bits let blocks stand side by side
  assign rdata_o = path_reg_i[REG_RDATA] ? rdata_q : rword_w; // see R17 R13 R12
  // product-term mode
  macrocell_if mc ();
  assign mc.literal = {mc_out_o[FB_N-1:0], pt_in_i}; // see R8 R9
  assign mc.reg_en = mc_reg_en_i;
  assign mc.term_mask = term_mask_i;
  assign mc.term_inv = term_inv_i;
  macrocell_array u_cells (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clr_n_i(clr_n_w),
    .mc(mc.array)
  );
  assign mc_out_o = pterm_mode_i ? mc.result : '0; // see R6
  // nine distinct local lines, the tenth repeats line zero
  assign local_out_o = pterm_mode_i ? {mc.result[0], mc.result[FB_N-1:0]}
                                    : {rdata_o[0], rdata_o[FB_N-1:0]}; // see R10
  sequence s_reg_read;
    !pterm_mode_i && path_reg_i[REG_RDATA] && clr_n_w && do_read_w;
  endsequence
  chk_out_reg_lag: assert property (@(posedge out_clk_i) disable iff (!reset_n_i)
    s_reg_read ##1 clr_n_w |-> rdata_q == $past(rword_w))
    else $error("read register did not capture word"); // see R17
  chk_local_dup: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    local_out_o[LOCAL_OUT_N-1] == local_out_o[0])
    else $error("tenth local line not duplicate"); // see R10
  chk_rom_no_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    func_w == FUNC_ROM |-> !do_write_w)
    else $error("rom written"); // see R2
  chk_clear_regs: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !clr_n_w |=> !wreq_q && waddr_q == '0)
    else $error("clear did not reset input registers"); // see R18
  chk_pterm_no_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    pterm_mode_i |-> !do_write_w && mc_out_o == mc.result)
    else $error("mode select broken"); // see R6
  chk_write_capture: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_w && clr_n_w |=> wreq_q == $past(write_request_i))
    else $error("write request not registered"); // see R4 R15
  chk_fifo_bounds: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_fifo_w |-> fifo_cnt_w <= depth_w)
    else $error("fifo count beyond depth"); // see R2
endmodule // embedded_memory_block
`default_nettype wire

// >>> verilog/macrocell_array.sv
// sixteen macrocells, each an or of two product terms with optional register
`default_nettype none
module macrocell_array
  import emb_pkg::*;
(
  // clock and clear
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clr_n_i,
  // terms and results
  macrocell_if.array mc
);
  logic [MACRO_N-1:0] sum_w;
  logic [MACRO_N-1:0] cell_q;
  genvar g;
  generate
    for (g = 0; g < MACRO_N; g++) begin : g_cell
      logic [LIT_W-1:0] lit_a_w;
      logic [LIT_W-1:0] lit_b_w;
      // unused literals are masked to one so they drop out of the and
      assign lit_a_w = (mc.literal ^ mc.term_inv[(2*g)*LIT_W +: LIT_W])
                       | ~mc.term_mask[(2*g)*LIT_W +: LIT_W];
      assign lit_b_w = (mc.literal ^ mc.term_inv[(2*g+1)*LIT_W +: LIT_W])
                       | ~mc.term_mask[(2*g+1)*LIT_W +: LIT_W];
      assign sum_w[g] = (&lit_a_w) | (&lit_b_w); // see R7
      assign mc.result[g] = mc.reg_en[g] ? cell_q[g] : sum_w[g]; // see R7
    end
  endgenerate
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cell_q <= '0;
    end else if (!clr_n_i) begin
      cell_q <= '0;
    end else begin
      cell_q <= sum_w;
    end
  end
  chk_cell_reg_path: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clr_n_i |=> ((mc.result ^ $past(sum_w)) & mc.reg_en & $past(mc.reg_en)) == '0)
    else $error("macrocell register path wrong"); // see R7
endmodule // macrocell_array
`default_nettype wire

// >>> verilog/macrocell_if.sv
// product-term literals and macrocell results between block and array
`default_nettype none
interface macrocell_if;
  import emb_pkg::*;
  logic [LIT_W-1:0] literal;
  logic [MACRO_N-1:0] result;
  logic [MACRO_N-1:0] reg_en;
  logic [MACRO_N*2*LIT_W-1:0] term_mask;
  logic [MACRO_N*2*LIT_W-1:0] term_inv;
  modport array (input literal, input reg_en, input term_mask, input term_inv,
                 output result);
  modport block (output literal, output reg_en, output term_mask, output term_inv,
                 input result);
endinterface
`default_nettype wire
